/* File: logic/omsm_pkg.sv */
// Constants and carrier types of the main service channel symbol mapper (mode I).
// Assumes a single sys_clk domain; all users write omsm_pkg::name.
// Behaviour
// RQ1 - Four common_interleaved_frames per transmission frame
// RQ2 - Concatenate four 55296-bit frames in order
// RQ3 - Counts 0..3 modulo 4 share one frame
// RQ4 - Frame count is time index modulo 5000
// RQ5 - Cut vector into 72 blocks, symbols 5..76
// RQ6 - QPSK from bit n and n plus K
// RQ7 - Permutation: thirteen times previous plus 511
// RQ8 - Keep values 256..1792, skip 1024
// RQ9 - Carrier index is list entry minus 1024
// RQ10 - Same reordering for every symbol from 2
// RQ11 - Output is previous carrier output times QPSK
// RQ12 - Symbols independent of transmission frame index
// RQ13 - Phase reference symbol seeds; carrier zero zero
// RQ14 - Symbols 2..4 fast_information_channel, data from 5
// RQ15 - K is 1536; pair n with n+1536
package omsm_pkg;

  localparam logic [15:0] FRAME_LAST_BIT = 16'hD7FF;
  localparam logic [11:0] BLOCK_LAST_BIT = 12'hBFF;
  localparam logic [11:0] HALF_BLOCK = 12'h600;
  localparam logic [10:0] CARRIER_COUNT = 11'h600;
  localparam logic [10:0] CARRIER_LAST = 11'h5FF;
  localparam logic [4:0] BLOCKS_PER_FRAME_LAST = 5'h11;
  localparam logic [1:0] SLOTS_PER_GROUP_LAST = 2'h3;
  localparam logic [12:0] FRAME_COUNT_MOD = 13'h1388;

  localparam logic [6:0] SYM_PHASE_REF = 7'h01;
  localparam logic [6:0] SYM_FIRST_DATA = 7'h02;
  localparam logic [6:0] SYM_FIRST_MAIN = 7'h05;
  localparam logic [6:0] SYM_LAST = 7'h4C;

  localparam logic [10:0] PERM_MULT = 11'h00D;
  localparam logic [10:0] PERM_ADD = 11'h1FF;
  localparam logic [10:0] PERM_LAST_STEP = 11'h7FF;
  localparam logic [10:0] PERM_START = 11'h000;
  localparam logic [10:0] KEEP_LOW = 11'h100;
  localparam logic [10:0] KEEP_HIGH = 11'h700;
  localparam logic [10:0] KEEP_SKIP = 11'h400;

  localparam logic [2:0] PHASE_ZERO = 3'h0;

  typedef enum logic [1:0] {
    ST_REF = 2'b00,
    ST_FILL_FAST = 2'b01,
    ST_FILL_MAIN = 2'b10,
    ST_MAP = 2'b11
  } omsm_state_type;

  // One bit of a block; frame start and count only on the first bit of a frame.
  typedef struct packed {
    logic valid;
    logic data;
    logic frameStart;
    logic [12:0] frameCount;
  } omsm_bit_type;

  // Phase reference in quarter turns, carriers -768..768 without zero, ascending.
  typedef struct packed {
    logic valid;
    logic [1:0] quarter;
  } omsm_ref_type;

  // Differential symbol: phase in eighths of a turn on one carrier.
  typedef struct packed {
    logic [6:0] symbol;
    logic signed [10:0] carrier;
    logic [2:0] phase;
  } omsm_cell_type;

endpackage

/* File: logic/omsm_perm_gen.sv */
// Congruential frequency interleaver sequence generator, one value per cycle.
// Assumes the consumer pulls kept values with outReady; start restarts the walk.
`timescale 1ns/1ps
`default_nettype none
module omsm_perm_gen (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic start,
  input wire logic outReady,
  output logic outValid,
  output logic [10:0] outValue,
  output logic busy
);

  logic [10:0] perm_reg;
  logic [10:0] perm_next;
  logic [10:0] step_reg;
  logic running_reg;
  logic keep;
  logic advance;

  assign perm_next = perm_reg * omsm_pkg::PERM_MULT + omsm_pkg::PERM_ADD; // RQ7
  assign keep = (perm_reg >= omsm_pkg::KEEP_LOW) && (perm_reg <= omsm_pkg::KEEP_HIGH)
    && (perm_reg != omsm_pkg::KEEP_SKIP); // RQ8
  // Skipped values cost a cycle each; a walk takes 2048 cycles at least
  assign advance = running_reg && (!keep || outReady);
  assign outValid = running_reg && keep;
  assign outValue = perm_reg;
  assign busy = running_reg;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      perm_reg <= omsm_pkg::PERM_START;
      step_reg <= 11'h000;
      running_reg <= 1'b0;
    end else if (ce) begin
      if (start) begin
        perm_reg <= omsm_pkg::PERM_START; // RQ7
        step_reg <= 11'h000;
        running_reg <= 1'b1;
      end else if (advance) begin
        if (step_reg == omsm_pkg::PERM_LAST_STEP) begin
          running_reg <= 1'b0;
        end else begin
          perm_reg <= perm_next;
          step_reg <= step_reg + 11'h001;
        end
      end
    end
  end

endmodule // omsm_perm_gen
`default_nettype wire

/* File: logic/omsm_mapper.sv */
// Main service channel block partitioner, QPSK mapper, frequency interleaver
// and differential modulator for transmission mode I.
// Assumes per transmission frame: 1536 reference phases, three 3072-bit
// fast_information_channel blocks, then four common_interleaved_frames in order.
`timescale 1ns/1ps
`default_nettype none
module omsm_mapper (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire omsm_pkg::omsm_ref_type refIn,
  output logic refReady,
  input wire omsm_pkg::omsm_bit_type bitIn,
  output logic bitReady,
  output logic cellValid,
  input wire logic cellReady,
  output var omsm_pkg::omsm_cell_type cellOut,
  output logic symbolDone,
  output logic frameDone,
  output logic alignError,
  output logic [6:0] symbolIndex,
  output logic [12:0] groupCount,
  output logic [15:0] dropCount
);

  omsm_pkg::omsm_state_type state_reg;
  omsm_pkg::omsm_state_type state_next;
  logic [6:0] symbol_reg;
  logic [11:0] fillIdx_reg;
  logic [4:0] blockInFrame_reg;
  logic [1:0] frameSlot_reg;
  logic [10:0] refIdx_reg;
  logic [10:0] mapIdx_reg;
  logic permStart_reg;
  logic [3071:0] bitBuf_reg;
  logic [2:0] phaseMem_reg [0:1535];
  logic cellValid_reg;
  omsm_pkg::omsm_cell_type cell_reg;
  logic symbolDone_reg;
  logic frameDone_reg;
  logic alignError_reg;
  logic [12:0] groupCount_reg;
  logic [15:0] dropCount_reg;

  logic refTake;
  logic bitTake;
  logic atFrameBoundary;
  logic countInRange;
  logic slotMatch;
  logic groupRestart;
  logic bitKeep;
  logic bitDrop;
  logic blockEnd;
  logic permValid;
  logic [10:0] permValue;
  logic permBusy;
  logic slotFree;
  logic mapTake;
  logic mapEnd;
  logic [10:0] carrierSlot;
  logic signed [10:0] carrierIdx;
  logic [11:0] imagIdx;
  logic bitRe;
  logic bitIm;
  logic [2:0] qpskPhase;
  logic [2:0] diffPhase;

  assign refReady = (state_reg == omsm_pkg::ST_REF);
  assign bitReady = (state_reg == omsm_pkg::ST_FILL_FAST) || (state_reg == omsm_pkg::ST_FILL_MAIN);
  assign refTake = ce && refReady && refIn.valid;
  assign bitTake = ce && bitReady && bitIn.valid;

  // Frame alignment checks only where a frame must begin
  assign atFrameBoundary = (state_reg == omsm_pkg::ST_FILL_MAIN) && (fillIdx_reg == 12'h000)
    && (blockInFrame_reg == 5'h00);
  assign countInRange = bitIn.frameCount < omsm_pkg::FRAME_COUNT_MOD; // RQ4
  // The modulus 5000 is a multiple of four, so the low two bits give the slot
  assign slotMatch = bitIn.frameStart && countInRange && (bitIn.frameCount[1:0] == frameSlot_reg); // RQ3
  assign groupRestart = bitIn.frameStart && countInRange && (bitIn.frameCount[1:0] == 2'b00); // RQ3
  assign bitKeep = bitTake && (!atFrameBoundary || slotMatch || groupRestart);
  assign bitDrop = bitTake && !bitKeep;
  assign blockEnd = bitKeep && (fillIdx_reg == omsm_pkg::BLOCK_LAST_BIT); // RQ5

  assign slotFree = !cellValid_reg || cellReady;
  assign mapTake = ce && (state_reg == omsm_pkg::ST_MAP) && permValid && slotFree;
  assign mapEnd = (state_reg == omsm_pkg::ST_MAP) && (mapIdx_reg == omsm_pkg::CARRIER_COUNT)
    && !permBusy && !permStart_reg;

  omsm_perm_gen u_perm (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .ce(ce),
    .start(permStart_reg),
    .outReady(slotFree && (state_reg == omsm_pkg::ST_MAP)),
    .outValid(permValid),
    .outValue(permValue),
    .busy(permBusy)
  );

  assign carrierIdx = $signed(permValue - omsm_pkg::KEEP_SKIP); // RQ9
  // Storage slot skips carrier zero: -768..-1 to 0..767, 1..768 to 768..1535
  assign carrierSlot = (permValue < omsm_pkg::KEEP_SKIP) ? (permValue - omsm_pkg::KEEP_LOW)
    : (permValue - omsm_pkg::KEEP_LOW - 11'h001);
  assign imagIdx = {1'b0, mapIdx_reg} + omsm_pkg::HALF_BLOCK; // RQ15
  assign bitRe = bitBuf_reg[mapIdx_reg]; // RQ6
  assign bitIm = bitBuf_reg[imagIdx]; // RQ6
  // Zero bit is +1; phases 1,3,5,7 eighths are the four scaled QPSK points
  assign qpskPhase = {bitIm, bitRe ^ bitIm, 1'b1}; // RQ6
  // Unit magnitude points multiply by adding phases modulo a full turn
  assign diffPhase = phaseMem_reg[carrierSlot] + qpskPhase; // RQ11

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      omsm_pkg::ST_REF: begin
        if (refTake && (refIdx_reg == omsm_pkg::CARRIER_LAST)) begin
          state_next = omsm_pkg::ST_FILL_FAST; // RQ14
        end
      end
      omsm_pkg::ST_FILL_FAST: begin
        if (blockEnd) begin
          state_next = omsm_pkg::ST_MAP;
        end
      end
      omsm_pkg::ST_FILL_MAIN: begin
        if (blockEnd) begin
          state_next = omsm_pkg::ST_MAP;
        end
      end
      omsm_pkg::ST_MAP: begin
        if (mapEnd) begin
          if (symbol_reg == omsm_pkg::SYM_LAST) begin
            state_next = omsm_pkg::ST_REF;
          end else if (symbol_reg + 7'h01 < omsm_pkg::SYM_FIRST_MAIN) begin
            state_next = omsm_pkg::ST_FILL_FAST; // RQ14
          end else begin
            state_next = omsm_pkg::ST_FILL_MAIN; // RQ14
          end
        end
      end
      default: begin
        state_next = omsm_pkg::ST_REF;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      state_reg <= omsm_pkg::ST_REF;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  // Symbol counter runs 1..76 and wraps with every transmission frame
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      symbol_reg <= omsm_pkg::SYM_PHASE_REF;
    end else if (ce) begin
      if (refTake && (refIdx_reg == omsm_pkg::CARRIER_LAST)) begin
        symbol_reg <= omsm_pkg::SYM_FIRST_DATA; // RQ10
      end else if (bitKeep && atFrameBoundary && !slotMatch) begin
        symbol_reg <= omsm_pkg::SYM_FIRST_MAIN; // RQ3
      end else if (mapEnd) begin
        if (symbol_reg == omsm_pkg::SYM_LAST) begin
          symbol_reg <= omsm_pkg::SYM_PHASE_REF; // RQ1
        end else begin
          symbol_reg <= symbol_reg + 7'h01; // RQ5
        end
      end
    end
  end

  // Position inside the concatenated vector: slot, block in frame, bit in block
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      fillIdx_reg <= 12'h000;
      blockInFrame_reg <= 5'h00;
      frameSlot_reg <= 2'b00;
    end else if (ce) begin
      if (state_reg == omsm_pkg::ST_REF) begin
        fillIdx_reg <= 12'h000;
        blockInFrame_reg <= 5'h00;
        frameSlot_reg <= 2'b00;
      end else if (bitKeep) begin
        if (blockEnd) begin
          fillIdx_reg <= 12'h000;
        end else begin
          fillIdx_reg <= fillIdx_reg + 12'h001; // RQ2
        end
        if (atFrameBoundary && !slotMatch) begin
          frameSlot_reg <= 2'b00; // RQ3
        end
      end else if (mapEnd && (symbol_reg >= omsm_pkg::SYM_FIRST_MAIN)) begin
        if (blockInFrame_reg == omsm_pkg::BLOCKS_PER_FRAME_LAST) begin
          blockInFrame_reg <= 5'h00;
          if (frameSlot_reg == omsm_pkg::SLOTS_PER_GROUP_LAST) begin
            frameSlot_reg <= 2'b00; // RQ1
          end else begin
            frameSlot_reg <= frameSlot_reg + 2'b01; // RQ2
          end
        end else begin
          blockInFrame_reg <= blockInFrame_reg + 5'h01; // RQ5
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      bitBuf_reg <= '0;
    end else if (ce && bitKeep) begin
      bitBuf_reg[fillIdx_reg] <= bitIn.data; // RQ5
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      refIdx_reg <= 11'h000;
    end else if (ce) begin
      if (refTake) begin
        if (refIdx_reg == omsm_pkg::CARRIER_LAST) begin
          refIdx_reg <= 11'h000;
        end else begin
          refIdx_reg <= refIdx_reg + 11'h001;
        end
      end
    end
  end

  // Per-carrier differential state; carrier zero is never stored, so it stays zero
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 1536; i++) begin
        phaseMem_reg[i] <= omsm_pkg::PHASE_ZERO;
      end
    end else if (ce) begin
      if (refTake) begin
        phaseMem_reg[refIdx_reg] <= {refIn.quarter, 1'b0}; // RQ13
      end else if (mapTake) begin
        phaseMem_reg[carrierSlot] <= diffPhase; // RQ11
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mapIdx_reg <= 11'h000;
      permStart_reg <= 1'b0;
    end else if (ce) begin
      permStart_reg <= blockEnd; // RQ10
      if (blockEnd) begin
        mapIdx_reg <= 11'h000;
      end else if (mapTake) begin
        mapIdx_reg <= mapIdx_reg + 11'h001; // RQ9
      end
    end
  end

  // Output slot holds a cell until taken; nothing depends on frame index m
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      cellValid_reg <= 1'b0;
      cell_reg <= '0;
    end else if (ce) begin
      if (mapTake) begin
        cellValid_reg <= 1'b1;
        cell_reg.symbol <= symbol_reg;
        cell_reg.carrier <= carrierIdx; // RQ9
        cell_reg.phase <= diffPhase; // RQ12
      end else if (cellReady) begin
        cellValid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      symbolDone_reg <= 1'b0;
      frameDone_reg <= 1'b0;
      alignError_reg <= 1'b0;
    end else if (ce) begin
      symbolDone_reg <= mapEnd;
      frameDone_reg <= mapEnd && (symbol_reg == omsm_pkg::SYM_LAST);
      alignError_reg <= bitTake && atFrameBoundary && !slotMatch; // RQ3
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      groupCount_reg <= 13'h0000;
      dropCount_reg <= 16'h0000;
    end else if (ce) begin
      if (bitKeep && atFrameBoundary && (bitIn.frameCount[1:0] == 2'b00)) begin
        groupCount_reg <= bitIn.frameCount; // RQ4
      end
      if (bitDrop && (dropCount_reg != 16'hFFFF)) begin
        dropCount_reg <= dropCount_reg + 16'h0001;
      end
    end
  end

  assign cellValid = cellValid_reg;
  assign cellOut = cell_reg;
  assign symbolDone = symbolDone_reg;
  assign frameDone = frameDone_reg;
  assign alignError = alignError_reg;
  assign symbolIndex = symbol_reg;
  assign groupCount = groupCount_reg;
  assign dropCount = dropCount_reg;

endmodule // omsm_mapper
`default_nettype wire

/* File: verification/omsm_mapper_chk.sv */
// Port checker for omsm_mapper, bound below.
// Assumes one sys_clk domain and resetn active low.
`timescale 1ns/1ps
`default_nettype none
module omsm_mapper_chk (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic ce,
  input wire omsm_pkg::omsm_ref_type refIn,
  input wire logic refReady,
  input wire omsm_pkg::omsm_bit_type bitIn,
  input wire logic bitReady,
  input wire logic cellValid,
  input wire logic cellReady,
  input wire omsm_pkg::omsm_cell_type cellOut,
  input wire logic symbolDone,
  input wire logic frameDone,
  input wire logic alignError,
  input wire logic [6:0] symbolIndex,
  input wire logic [12:0] groupCount,
  input wire logic [15:0] dropCount
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_stall;
    cellValid && !cellReady && ce;
  endsequence
  sequence s_held;
    cellValid && $stable(cellOut);
  endsequence
  a_cell_hold: assert property (s_stall |=> s_held) else $error("cell not held");
  a_carrier_range: assert property (cellValid |-> cellOut.carrier != 11'sh000 &&
    cellOut.carrier >= 11'sh500 && cellOut.carrier <= 11'sh300) else $error("bad carrier");
  a_phase_parity: assert property (cellValid |-> cellOut.phase[0] == !cellOut.symbol[0])
    else $error("bad phase parity");
  a_symbol_range: assert property (cellValid |-> cellOut.symbol >= 7'h02 && cellOut.symbol <= 7'h4C)
    else $error("bad cell symbol");
  a_bit_symbol: assert property (bitReady |-> symbolIndex >= 7'h02 && !refReady)
    else $error("bits taken outside data");
  a_ref_symbol: assert property (refReady |-> symbolIndex == 7'h01) else $error("ref outside symbol 1");
  a_group_slot: assert property (groupCount[1:0] == 2'h0 && groupCount < 13'h1388)
    else $error("bad group count");
  a_drop_step: assert property ($past(resetn) && dropCount != $past(dropCount) |->
    dropCount == $past(dropCount) + 16'h0001) else $error("bad drop step");
endmodule // omsm_mapper_chk
bind omsm_mapper omsm_mapper_chk chk (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .refIn(refIn),
  .refReady(refReady), .bitIn(bitIn), .bitReady(bitReady), .cellValid(cellValid), .cellReady(cellReady),
  .cellOut(cellOut), .symbolDone(symbolDone), .frameDone(frameDone), .alignError(alignError),
  .symbolIndex(symbolIndex), .groupCount(groupCount), .dropCount(dropCount));
`default_nettype wire

/* File: verification/omsm_cell_sink.sv */
// Downstream symbol generator model taking cells.
// Assumes cellValid from omsm_mapper in the sys_clk domain.
`timescale 1ns/1ps
`default_nettype none
module omsm_cell_sink (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic cellValid,
  output logic cellReady
);
  logic [2:0] stallCnt_reg;
  always_ff @(posedge sys_clk) begin
    if (!resetn) stallCnt_reg <= 3'h0;
    else stallCnt_reg <= stallCnt_reg + 3'h1;
  end
  // Two stalls in eight, so standing cells get exercised
  assign cellReady = resetn && cellValid && stallCnt_reg[2:1] != 2'h3;
endmodule // omsm_cell_sink
`default_nettype wire

/* File: verification/ofdm_msc_symbol_mapper_tb.sv */
// Bench for omsm_mapper: reference load, three fast info blocks, one main block.
// Assumes omsm_cell_sink downstream and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module ofdm_msc_symbol_mapper_tb;
  omsm_pkg::omsm_ref_type refIn;
  omsm_pkg::omsm_bit_type bitIn;
  omsm_pkg::omsm_cell_type cellOut;
  logic sys_clk, resetn, ce, refReady, bitReady, cellValid, cellReady, symbolDone, frameDone, alignError;
  logic [6:0] symbolIndex;
  logic [12:0] groupCount;
  logic [15:0] dropCount;
  int badCount, samplesChecked, cellIdx, expSym, doneCnt, errCnt, frmCnt, v, nk, k;
  int keep [0:1535];
  logic [2:0] mem [0:1536];
  logic [2:0] e;
  omsm_mapper uut (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .refIn(refIn), .refReady(refReady),
    .bitIn(bitIn), .bitReady(bitReady), .cellValid(cellValid), .cellReady(cellReady), .cellOut(cellOut),
    .symbolDone(symbolDone), .frameDone(frameDone), .alignError(alignError), .symbolIndex(symbolIndex),
    .groupCount(groupCount), .dropCount(dropCount));
  omsm_cell_sink sink (.sys_clk(sys_clk), .resetn(resetn), .cellValid(cellValid), .cellReady(cellReady));
  always #2.5 sys_clk = ~sys_clk;
  task automatic end_sim;
    if (badCount == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic fail(input logic [15:0] got, input logic [15:0] exp);
    badCount++;
    $display("mismatch at %0t: got %h expected %h", $time, got, exp);
  endtask
  task automatic cmpVal(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) fail(got, exp);
  endtask
  task automatic cmpCell(input omsm_pkg::omsm_cell_type got, input omsm_pkg::omsm_cell_type exp);
    samplesChecked++;
    if (got !== exp) begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic pat(input int s, input int n);
    return 1'((n * 37 + s * 11) >> 3);
  endfunction
  always @(posedge sys_clk) begin
    if (resetn === 1'b1 && ce === 1'b1 && cellValid === 1'b1 && cellReady === 1'b1) begin
      k = keep[cellIdx] - 1024;
      e = mem[k + 768] + {pat(expSym, cellIdx + 1536), pat(expSym, cellIdx) ^ pat(expSym, cellIdx + 1536), 1'b1};
      mem[k + 768] = e;
      cmpCell(cellOut, '{symbol: 7'(expSym), carrier: 11'(k), phase: e});
      cellIdx++;
      if (cellIdx == 1536) begin
        cellIdx = 0;
        expSym++;
      end
    end
    if (symbolDone === 1'b1) doneCnt++;
    if (alignError === 1'b1) errCnt++;
    if (frameDone === 1'b1) frmCnt++;
  end
  task automatic waitFor(input bit isRef, input bit isDone, input int cnt);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while ((isDone ? doneCnt < cnt : (isRef ? refReady : bitReady) !== 1'b1) && n < 9000);
    if (n >= 9000) begin
      badCount++;
      end_sim();
    end
    // The last cell of a symbol may still stand stalled when the done pulse shows
    if (isDone) begin
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task automatic sendBit(input logic d, input logic st, input logic [12:0] cnt);
    bitIn <= '{valid: 1'b1, data: d, frameStart: st, frameCount: cnt};
    waitFor(1'b0, 1'b0, 0);
  endtask
  task automatic sendBlock(input int s, input logic [12:0] cnt);
    for (int n = 0; n < 3072; n++) begin
      sendBit(pat(s, n), 1'(n == 0 && s == 5), cnt);
    end
    bitIn <= '0;
    @(posedge sys_clk);
  endtask
  task automatic test_ref_load;
    cmpVal({14'h0000, refReady, bitReady}, 16'h0002);
    cmpVal({9'h000, symbolIndex}, 16'h0001);
    cmpVal(dropCount, 16'h0000);
    for (int j = 0; j < 1536; j++) begin
      refIn <= '{valid: 1'b1, quarter: 2'(j)};
      mem[j < 768 ? j : j + 1] = {2'(j), 1'b0};
      waitFor(1'b1, 1'b0, 0);
    end
    refIn <= '0;
    @(posedge sys_clk);
    cmpVal({14'h0000, refReady, bitReady}, 16'h0001);
    cmpVal({9'h000, symbolIndex}, 16'h0002);
  endtask
  task automatic test_fast_blocks;
    for (int s = 2; s < 5; s++) begin
      sendBlock(s, 13'h0000);
    end
    waitFor(1'b0, 1'b1, 3);
    cmpVal(16'(expSym), 16'h0005);
  endtask
  task automatic test_main_align;
    // Clock enable low: an offered misaligned bit must not be taken
    ce <= 1'b0;
    sendBit(1'b0, 1'b1, 13'h0001);
    @(posedge sys_clk);
    cmpVal(dropCount, 16'h0000);
    cmpVal(16'(errCnt), 16'h0000);
    ce <= 1'b1;
    sendBit(1'b0, 1'b1, 13'h0001);
    sendBit(1'b0, 1'b1, 13'h138C);
    sendBlock(5, 13'h0008);
    waitFor(1'b0, 1'b1, 4);
    cmpVal(dropCount, 16'h0002);
    cmpVal(16'(errCnt), 16'h0002);
    cmpVal({3'h0, groupCount}, 16'h0008);
    cmpVal(16'(expSym), 16'h0006);
    cmpVal(16'(frmCnt), 16'h0000);
  endtask
  initial begin
    sys_clk = 1'b0;
    resetn = 1'b0;
    ce = 1'b1;
    refIn = '0;
    bitIn = '0;
    expSym = 2;
    for (int i = 0; i < 2048; i++) begin
      if (v >= 256 && v <= 1792 && v != 1024) begin
        keep[nk] = v;
        nk++;
      end
      v = (13 * v + 511) % 2048;
    end
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    test_ref_load();
    test_fast_blocks();
    test_main_align();
    end_sim();
  end
endmodule // ofdm_msc_symbol_mapper_tb
`default_nettype wire
